// ==== include/dptl_defines.vh ====
`ifndef DPTL_DEFINES_VH
`define DPTL_DEFINES_VH
// Register byte offsets
`define DPTL_REG_CTRL        12'h000
`define DPTL_REG_TERM_SEL    12'h004
`define DPTL_REG_OUT_SEL     12'h008
`define DPTL_REG_STATUS      12'h00C
`define DPTL_REG_BLK_FREQ    12'h010
`define DPTL_REG_BLK_CURR    12'h014
`define DPTL_REG_LIVE        12'h018
// Control fields
`define DPTL_CTRL_FAN_MODE   0
`define DPTL_CTRL_RESET_REQ  1
`define DPTL_CTRL_DELAY_LSB  8
`define DPTL_CTRL_DELAY_W    10
// Reset values
`define DPTL_FAN_MODE_RST    1'b0
`define DPTL_DELAY_RST       10'h000
`define DPTL_DELAY_MAX       10'd600
`define DPTL_TERM_SEL_RST    30'h0000_0000
`define DPTL_OUT_SEL_RST     12'h000
// Function codes
`define DPTL_FUNC_RESET      6'd3
`define DPTL_FUNC_BLOCK      6'd5
`define DPTL_FUNC_MAX        6'd54
`define DPTL_OUT_FAN_WARN    6'd8
`define DPTL_OUT_LOW_VOLT    6'd11
// Timing: tick period in ms, clock in kHz
`define DPTL_TICK_MS         100
`define DPTL_CLK_KHZ         100000
`define DPTL_TICK_CYCLES     (`DPTL_TICK_MS * `DPTL_CLK_KHZ)
`endif

// ==== rtl/dptl_trip_logic.v ====
// Functional notes
// - Fan trip mode: block output, flag trip
// - Fan warning mode: keep running, signal warning
// - Outputs show fan error on code 8, warning mode only
// - Overtemperature always blocks output
// - Undervoltage stops output immediately
// - Undervoltage trip after settable delay
// - Outputs show undervoltage on code 11
// - Undervoltage warning ignores trip delay
// - Five input terminals, functions 0 to 54
// - Block input stops output, shows indication
// - Latch frequency and current at block
// - Resume needs release then new run
// - Keypad or reset terminal clears trips
// - Fan fault mode defaults to trip
`timescale 1ns/100ps
`include "dptl_defines.vh"
module dptl_trip_logic #(
    parameter TICK_CYCLES = `DPTL_TICK_CYCLES,       // Cycles per 0.1 s tick
    parameter NUM_TERM    = 5                        // Input terminal count
) (
    input  wire                CORE_CLK_IN,          // System clock
    input  wire                SYS_RST_IN,           // Sync reset, high
    input  wire [31:0]         HADDR_IN,             // AHB address
    input  wire [1:0]          HTRANS_IN,            // AHB transfer type
    input  wire                HWRITE_IN,            // AHB write
    input  wire [2:0]          HSIZE_IN,             // AHB size
    input  wire [31:0]         HWDATA_IN,            // AHB write data
    input  wire                HSEL_IN,              // AHB select
    input  wire                HREADY_IN,            // AHB bus ready
    output wire [31:0]         HRDATA_OUT,           // AHB read data
    output wire                HREADYOUT_OUT,        // AHB slave ready
    output wire                HRESP_OUT,            // AHB response
    input  wire                FAN_ERR_IN,           // Cooling fan error
    input  wire                UNDERVOLT_IN,         // DC link undervoltage
    input  wire                OVERTEMP_IN,          // Overtemperature
    input  wire [NUM_TERM-1:0] TERM_IN,              // Input terminals
    input  wire                KEYPAD_RESET_IN,      // Keypad reset key
    input  wire                RUN_CMD_IN,           // Run command level
    input  wire [15:0]         OP_FREQ_IN,           // Live frequency
    input  wire [15:0]         OP_CURR_IN,           // Live current
    output reg                 POWER_OUTPUT_INHIBIT_OUT, // Blocks power stage
    output reg                 FAN_TRIP_OUT,         // Fan trip display
    output reg                 UV_TRIP_OUT,          // Undervoltage trip
    output reg                 BLOCK_IND_OUT,        // Output block display
    output reg                 DIGITAL_OUT,          // Open collector output
    output reg                 RELAY_OUT             // Relay output
);

    // Register state
    reg                        fan_mode;             // 0 trip, 1 warning
    reg [`DPTL_CTRL_DELAY_W-1:0] uv_delay;           // Delay in ticks
    reg [6*NUM_TERM-1:0]       term_sel;             // Terminal functions
    reg [5:0]                  dout_sel;             // Digital output function
    reg [5:0]                  relay_sel;            // Relay function
    reg [15:0]                 blk_freq;             // Latched frequency
    reg [15:0]                 blk_curr;             // Latched current
    reg                        sw_reset;             // Software reset pulse
    // Bus data phase
    reg                        dp_write;             // Write pending
    reg                        dp_read;              // Read pending
    reg [11:0]                 dp_addr;              // Latched offset
    reg [31:0]                 rdata;                // Read data
    // Protection state
    reg [31:0]                 tick_cnt;             // Tick prescaler
    reg [`DPTL_CTRL_DELAY_W-1:0] uv_cnt;             // Elapsed ticks
    reg                        blocked;              // Block latch
    reg                        blk_prev;             // Block input history
    reg                        run_prev;             // Run command history
    wire                       tick;                 // 0.1 s strobe
    wire [NUM_TERM-1:0]        term_blk;             // Per-terminal block
    wire [NUM_TERM-1:0]        term_rst;             // Per-terminal reset
    wire                       blk_in;               // Any block terminal
    wire                       rst_req;              // Any reset request
    wire                       fan_warn;             // Fan warning level

    // Forces a selection above the legal function range to 0
    function [5:0] dptl_clamp;
        input [5:0] v;
        begin
            dptl_clamp = (v > `DPTL_FUNC_MAX) ? 6'd0 : v;
        end
    endfunction

    // Evaluates one output function code
    function dptl_out_fn;
        input [5:0] sel;
        input       fan;
        input       uv;
        begin
            dptl_out_fn = ((sel == `DPTL_OUT_FAN_WARN) && fan) ||
                          ((sel == `DPTL_OUT_LOW_VOLT) && uv);
        end
    endfunction

    // Decode each terminal against its function
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TERM; gi = gi + 1)
        begin : g_term
            assign term_blk[gi] = TERM_IN[gi] &&
                (term_sel[6*gi +: 6] == `DPTL_FUNC_BLOCK);
            assign term_rst[gi] = TERM_IN[gi] &&
                (term_sel[6*gi +: 6] == `DPTL_FUNC_RESET);
        end
    endgenerate

    assign blk_in   = |term_blk;
    assign rst_req  = KEYPAD_RESET_IN || (|term_rst) || sw_reset;
    assign fan_warn = fan_mode && FAN_ERR_IN;
    assign tick     = (tick_cnt == TICK_CYCLES - 1);

    // Bus slave: zero wait states, always OKAY
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT     = 1'b0;
    assign HRDATA_OUT    = rdata;

    // Address phase capture
    always @(posedge CORE_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 12'h000;
        end
        else if (HREADY_IN)
        begin
            dp_write <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
            dp_read  <= HSEL_IN && HTRANS_IN[1] && !HWRITE_IN;
            dp_addr  <= HADDR_IN[11:0];
        end
    end

    // Register writes
    always @(posedge CORE_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            fan_mode  <= `DPTL_FAN_MODE_RST;
            uv_delay  <= `DPTL_DELAY_RST;
            term_sel  <= `DPTL_TERM_SEL_RST;
            dout_sel  <= 6'd0;
            relay_sel <= 6'd0;
            sw_reset  <= 1'b0;
        end
        else
        begin
            sw_reset <= 1'b0;
            if (dp_write)
            begin
                case (dp_addr)
                    `DPTL_REG_CTRL:
                    begin
                        fan_mode <= HWDATA_IN[`DPTL_CTRL_FAN_MODE];
                        sw_reset <= HWDATA_IN[`DPTL_CTRL_RESET_REQ];
                        // Clamp to 60 s
                        if (HWDATA_IN[`DPTL_CTRL_DELAY_LSB +: `DPTL_CTRL_DELAY_W] >
                            `DPTL_DELAY_MAX)
                            uv_delay <= `DPTL_DELAY_MAX;
                        else
                            uv_delay <= HWDATA_IN[`DPTL_CTRL_DELAY_LSB +: `DPTL_CTRL_DELAY_W];
                    end
                    `DPTL_REG_TERM_SEL:
                    begin
                        term_sel[0 +: 6]  <= dptl_clamp(HWDATA_IN[5:0]);
                        term_sel[6 +: 6]  <= dptl_clamp(HWDATA_IN[11:6]);
                        term_sel[12 +: 6] <= dptl_clamp(HWDATA_IN[17:12]);
                        term_sel[18 +: 6] <= dptl_clamp(HWDATA_IN[23:18]);
                        term_sel[24 +: 6] <= dptl_clamp(HWDATA_IN[29:24]);
                    end
                    `DPTL_REG_OUT_SEL:
                    begin
                        dout_sel  <= HWDATA_IN[5:0];
                        relay_sel <= HWDATA_IN[11:6];
                    end
                    default:
                    begin
                        sw_reset <= 1'b0;   // Unmapped: ignored
                    end
                endcase
            end
        end
    end

    // Register reads, registered in data phase
    always @(posedge CORE_CLK_IN)
    begin
        if (SYS_RST_IN)
            rdata <= 32'h0000_0000;
        else if (HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN)
        begin
            case (HADDR_IN[11:0])
                `DPTL_REG_CTRL:     rdata <= {14'h0000, uv_delay, 6'h00, 1'b0, fan_mode};
                `DPTL_REG_TERM_SEL: rdata <= {2'b00, term_sel};
                `DPTL_REG_OUT_SEL:  rdata <= {20'h0_0000, relay_sel, dout_sel};
                `DPTL_REG_STATUS:   rdata <= {26'h000_0000, POWER_OUTPUT_INHIBIT_OUT,
                                              BLOCK_IND_OUT, UV_TRIP_OUT, FAN_TRIP_OUT,
                                              UNDERVOLT_IN, FAN_ERR_IN};
                `DPTL_REG_BLK_FREQ: rdata <= {16'h0000, blk_freq};
                `DPTL_REG_BLK_CURR: rdata <= {16'h0000, blk_curr};
                `DPTL_REG_LIVE:     rdata <= {OP_CURR_IN, OP_FREQ_IN};
                default:            rdata <= 32'h0000_0000;
            endcase
        end
    end

    // 0.1 s tick prescaler, restarted while voltage is good
    always @(posedge CORE_CLK_IN)
    begin
        if (SYS_RST_IN || !UNDERVOLT_IN)
            tick_cnt <= 32'h0000_0000;
        else if (tick)
            tick_cnt <= 32'h0000_0000;
        else
            tick_cnt <= tick_cnt + 32'h0000_0001;
    end

    // Undervoltage delay counter and trip
    always @(posedge CORE_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            uv_cnt      <= 10'd0;
            UV_TRIP_OUT <= 1'b0;
        end
        else
        begin
            if (!UNDERVOLT_IN)
                uv_cnt <= 10'd0;
            else if (tick && (uv_cnt < uv_delay))
                uv_cnt <= uv_cnt + 10'd1;
            // Set wins over reset request
            if (UNDERVOLT_IN && (uv_cnt >= uv_delay))
                UV_TRIP_OUT <= 1'b1;
            else if (rst_req)
                UV_TRIP_OUT <= 1'b0;
        end
    end

    // Fan trip flag
    always @(posedge CORE_CLK_IN)
    begin
        if (SYS_RST_IN)
            FAN_TRIP_OUT <= 1'b0;
        else if (!fan_mode && FAN_ERR_IN)
            FAN_TRIP_OUT <= 1'b1;
        else if (rst_req)
            FAN_TRIP_OUT <= 1'b0;
    end

    // Output block latch and snapshot
    always @(posedge CORE_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            blocked  <= 1'b0;
            blk_prev <= 1'b0;
            run_prev <= 1'b0;
            blk_freq <= 16'h0000;
            blk_curr <= 16'h0000;
        end
        else
        begin
            blk_prev <= blk_in;
            run_prev <= RUN_CMD_IN;
            if (blk_in && !blocked)
            begin
                blocked  <= 1'b1;
                blk_freq <= OP_FREQ_IN;
                blk_curr <= OP_CURR_IN;
            end
            else if (blocked && !blk_in && !blk_prev && RUN_CMD_IN && !run_prev)
                blocked <= 1'b0;
        end
    end

    // Power inhibit, indications and output terminals
    always @(posedge CORE_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            POWER_OUTPUT_INHIBIT_OUT <= 1'b0;
            BLOCK_IND_OUT            <= 1'b0;
            DIGITAL_OUT              <= 1'b0;
            RELAY_OUT                <= 1'b0;
        end
        else
        begin
            POWER_OUTPUT_INHIBIT_OUT <= FAN_TRIP_OUT || (!fan_mode && FAN_ERR_IN)
                                     || OVERTEMP_IN
                                     || UNDERVOLT_IN || UV_TRIP_OUT
                                     || blocked || blk_in;
            BLOCK_IND_OUT <= blocked || blk_in;
            DIGITAL_OUT   <= dptl_out_fn(dout_sel, fan_warn, UNDERVOLT_IN);
            RELAY_OUT     <= dptl_out_fn(relay_sel, fan_warn, UNDERVOLT_IN);
        end
    end

endmodule

// ==== sim/dptl_trip_asserts.sv ====
`timescale 1ns/100ps
module dptl_trip_asserts #(
    parameter NUM_TERM = 5                              // Terminal count
) (
    input wire                CORE_CLK_IN,              // Clock
    input wire                SYS_RST_IN,               // Sync reset
    input wire                FAN_ERR_IN,               // Fan error
    input wire                UNDERVOLT_IN,             // Undervoltage
    input wire                OVERTEMP_IN,              // Overtemperature
    input wire [NUM_TERM-1:0] TERM_IN,                  // Terminals
    input wire                RUN_CMD_IN,               // Run command
    input wire                POWER_OUTPUT_INHIBIT_OUT, // Output blocked
    input wire                FAN_TRIP_OUT,             // Fan trip
    input wire                UV_TRIP_OUT,              // Undervoltage trip
    input wire                BLOCK_IND_OUT,            // Block display
    input wire                DIGITAL_OUT,              // Open collector
    input wire                RELAY_OUT                 // Relay
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    // Undervoltage newly seen
    sequence s_uv_rise;
        !UNDERVOLT_IN ##1 UNDERVOLT_IN;
    endsequence
    // Block display just ended
    sequence s_blk_end;
        BLOCK_IND_OUT ##1 !BLOCK_IND_OUT;
    endsequence
    a_fan_trip_blocks: assert property (FAN_TRIP_OUT |-> POWER_OUTPUT_INHIBIT_OUT)
        else $error("Fan trip without output block");
    a_hot_blocks: assert property (OVERTEMP_IN |=> POWER_OUTPUT_INHIBIT_OUT)
        else $error("Overtemperature did not block output");
    a_uv_stops_first: assert property (s_uv_rise |=> POWER_OUTPUT_INHIBIT_OUT)
        else $error("Undervoltage did not stop output");
    a_uv_trip_cause: assert property ($rose(UV_TRIP_OUT) |-> $past(UNDERVOLT_IN))
        else $error("Undervoltage trip without condition");
    a_blk_blocks: assert property (BLOCK_IND_OUT |-> POWER_OUTPUT_INHIBIT_OUT)
        else $error("Block display without output block");
    a_blk_cause: assert property ($rose(BLOCK_IND_OUT) |-> $past(|TERM_IN))
        else $error("Block display without terminal");
    a_blk_new_run: assert property (s_blk_end |-> RUN_CMD_IN || $past(RUN_CMD_IN))
        else $error("Block released without run command");
    a_warn_cause: assert property ($rose(DIGITAL_OUT) || $rose(RELAY_OUT)
        |-> $past(FAN_ERR_IN) || $past(UNDERVOLT_IN))
        else $error("Warning output without cause");
endmodule

// ==== sim/dptl_operator_model.sv ====
`timescale 1ns/100ps
module dptl_operator_model #(
    parameter RST_TERM = 0,                 // Reset terminal index
    parameter BLK_TERM = 1                  // Block terminal index
) (
    input  wire logic       clk_in,         // Clock
    input  wire logic       rst_in,         // Sync reset
    input  wire logic       reset_req_in,   // Wants trip reset
    input  wire logic       block_req_in,   // Wants output block
    input  wire logic       key_req_in,     // Wants keypad reset
    input  wire logic       run_req_in,     // Wants to run
    output logic      [4:0] term_out,       // Terminal levels
    output logic            key_out,        // Keypad key
    output logic            run_out         // Run command
);
    // Operator actions, one edge after the request
    always @(posedge clk_in)
        if (rst_in)
        begin
            term_out <= 5'h00;
            key_out  <= 1'b0;
            run_out  <= 1'b0;
        end
        else
        begin
            term_out[RST_TERM] <= reset_req_in;
            term_out[BLK_TERM] <= block_req_in;
            key_out            <= key_req_in;
            if (block_req_in)
                run_out <= 1'b0;
            else if (run_req_in && !term_out[BLK_TERM])
                run_out <= 1'b1;
        end
endmodule

// ==== sim/test_dptl_trip_logic.sv ====
`timescale 1ns/100ps
`include "dptl_defines.vh"
module test_dptl_trip_logic;
    logic        clk = 0, rst = 1, hwrite = 0, chk = 0;      // Clock, reset, strobes
    logic        fan = 0, uv = 0, ot = 0;                    // Detector levels
    logic        rst_req = 0, blk_req = 0, key_req = 0, run_req = 1; // Operator wishes
    logic [1:0]  htrans = 0;                                 // Transfer type
    logic [31:0] haddr = 0, hwdata = 0, s;                   // Bus and seen value
    logic [15:0] freq = 0, curr = 0, f0, c0;                 // Live and saved values
    logic [32:0] q[$], e;                                    // Expected results
    wire  [31:0] rdata;                                      // Read data
    wire  [4:0]  term;                                       // Terminal levels
    wire  [5:0]  pins;                                       // Protection outputs
    wire         rdy, key, run, resp;                        // Ready, keypad, run, response
    int          error_cnt = 0, comparisons = 0, cyc = 0, k; // Counters
    always #5 clk = ~clk;
    dptl_trip_logic #(.TICK_CYCLES(10)) i_dptl_trip_logic (
        .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HSEL_IN(1'b1),
        .HREADY_IN(rdy), .HRDATA_OUT(rdata), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp),
        .FAN_ERR_IN(fan), .UNDERVOLT_IN(uv), .OVERTEMP_IN(ot), .TERM_IN(term),
        .KEYPAD_RESET_IN(key), .RUN_CMD_IN(run), .OP_FREQ_IN(freq), .OP_CURR_IN(curr),
        .POWER_OUTPUT_INHIBIT_OUT(pins[5]), .FAN_TRIP_OUT(pins[4]), .UV_TRIP_OUT(pins[3]),
        .BLOCK_IND_OUT(pins[2]), .DIGITAL_OUT(pins[1]), .RELAY_OUT(pins[0]));
    dptl_operator_model i_dptl_operator_model (
        .clk_in(clk), .rst_in(rst), .reset_req_in(rst_req), .block_req_in(blk_req),
        .key_req_in(key_req), .run_req_in(run_req), .term_out(term), .key_out(key),
        .run_out(run));
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One word transfer; on a read d is the expected data
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        if (!wr)
            q.push_back({1'b0, d});
        chk    <= !wr;
        do @(posedge clk); while (rdy !== 1'b1);
        chk    <= 1'b0;
    endtask
    // Note expected output levels for the next cycle
    task pin(input logic [5:0] x);
        @(posedge clk);
        q.push_back({27'h0, x} | 33'h1_0000_0000);
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
    endtask
    task print_verdict;
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Monitor: oldest note against what the outputs show
    always @(negedge clk)
        if (chk === 1'b1)
        begin
            e = q.pop_front();
            s = e[32] ? {26'h0, pins} : rdata;
            comparisons++;
            if (s !== e[31:0])
                $display("ERROR %s exp %h seen %h", e[32] ? "pins" : "hrdata", e[31:0], s);
            if (s !== e[31:0])
                error_cnt++;
            if (!e[32] && resp !== 1'b0)
            begin
                $display("ERROR hresp exp 0 seen %b", resp);
                error_cnt++;
            end
        end
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    initial
    begin
        void'($urandom(9368));
        tick(16);
        rst <= 1'b0;
        bus(0, `DPTL_REG_CTRL, 32'h0000_0000);
        bus(1, `DPTL_REG_TERM_SEL, 32'h0003_C143);
        bus(0, `DPTL_REG_TERM_SEL, 32'h0000_0143);
        bus(1, `DPTL_REG_OUT_SEL, 32'h0000_02C8);
        bus(0, 32'h0000_001C, 32'h0000_0000);
        fan <= 1'b1;
        tick(3);
        pin(6'h30);
        bus(0, `DPTL_REG_STATUS, 32'h0000_0025);
        fan <= 1'b0;
        tick(3);
        pin(6'h30);
        rst_req <= 1'b1;
        tick(3);
        rst_req <= 1'b0;
        tick(3);
        pin(6'h00);
        bus(1, `DPTL_REG_CTRL, 32'h0000_0303);
        bus(0, `DPTL_REG_CTRL, 32'h0000_0301);
        for (k = 0; k < 2; k++)
        begin
            if (k == 1)
                bus(1, `DPTL_REG_OUT_SEL, 32'h0000_020B);
            fan <= 1'b1;
            tick(3);
            pin(k ? 6'h01 : 6'h02);
            ot <= 1'b1;
            tick(3);
            pin(k ? 6'h21 : 6'h22);
            fan <= 1'b0;
            ot  <= 1'b0;
            uv  <= 1'b1;
            tick(3);
            pin(k ? 6'h22 : 6'h21);
            uv <= 1'b0;
            tick(3);
        end
        uv <= 1'b1;
        tick(20);
        uv <= 1'b0;
        tick(2);
        uv <= 1'b1;
        tick(25);
        pin(6'h22);
        tick(15);
        pin(6'h2A);
        uv      <= 1'b0;
        key_req <= 1'b1;
        tick(3);
        key_req <= 1'b0;
        tick(3);
        pin(6'h00);
        {f0, c0} = $urandom;
        freq <= f0;
        curr <= c0;
        tick(2);
        blk_req <= 1'b1;
        run_req <= 1'b0;
        tick(4);
        freq <= ~f0;
        curr <= ~c0;
        pin(6'h24);
        bus(0, `DPTL_REG_BLK_FREQ, {16'h0000, f0});
        bus(0, `DPTL_REG_BLK_CURR, {16'h0000, c0});
        blk_req <= 1'b0;
        tick(5);
        pin(6'h24);
        run_req <= 1'b1;
        tick(4);
        pin(6'h00);
        bus(1, `DPTL_REG_CTRL, 32'h0003_FF00);
        fan <= 1'b1;
        bus(0, `DPTL_REG_CTRL, 32'h0002_5800);
        fan <= 1'b0;
        bus(1, `DPTL_REG_CTRL, 32'h0002_5802);
        tick(2);
        pin(6'h00);
        bus(0, `DPTL_REG_LIVE, {~c0, ~f0});
        print_verdict();
    end
endmodule
bind dptl_trip_logic dptl_trip_asserts #(.NUM_TERM(NUM_TERM)) i_dptl_trip_asserts (
    .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .FAN_ERR_IN(FAN_ERR_IN),
    .UNDERVOLT_IN(UNDERVOLT_IN), .OVERTEMP_IN(OVERTEMP_IN), .TERM_IN(TERM_IN),
    .RUN_CMD_IN(RUN_CMD_IN), .POWER_OUTPUT_INHIBIT_OUT(POWER_OUTPUT_INHIBIT_OUT),
    .FAN_TRIP_OUT(FAN_TRIP_OUT), .UV_TRIP_OUT(UV_TRIP_OUT), .BLOCK_IND_OUT(BLOCK_IND_OUT),
    .DIGITAL_OUT(DIGITAL_OUT), .RELAY_OUT(RELAY_OUT));
